// ==== hdl/sync_rom_pkg.sv ====
// Constants and types shared by the synchronous burst ROM read port
package sync_rom_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W = 13;
  localparam int ROW_W = 13;
  localparam int COL_W = 8;
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int ARR_AW = 20;

  // ****************************************
  // Mode register field positions and codes
  // ****************************************
  localparam int MR_LEN_LSB = 0;
  localparam int MR_TYPE_BIT = 2;
  localparam int MR_LAT_LSB = 3;
  localparam int MR_RSV_LO_BIT = 7;
  localparam int MR_RSV_HI_BIT = 8;
  localparam logic [2:0] LAT_CODE_4 = 3'h3;
  localparam logic [2:0] LAT_CODE_5 = 3'h4;
  localparam logic [1:0] LEN_CODE_4 = 2'h1;
  localparam logic [1:0] LEN_CODE_8 = 2'h2;
  localparam logic [2:0] LAT_4 = 3'h4;
  localparam logic [2:0] LAT_5 = 3'h5;

  // ****************************************
  // Power-on mode settings
  // ****************************************
  localparam logic [2:0] RESET_LAT = LAT_5;
  localparam logic RESET_INTERLEAVE = 1'b0;
  localparam logic RESET_LEN8 = 1'b0;

  // ****************************************
  // Timing counts and burst masks
  // ****************************************
  localparam logic [2:0] ISSUE_LEAD = 3'h3;
  localparam logic [1:0] MRS_BLANK = 2'h3;
  localparam logic [2:0] MASK_LEN4 = 3'h3;
  localparam logic [2:0] MASK_LEN8 = 3'h7;

  // ****************************************
  // Operating states
  // ****************************************
  typedef enum logic [3:0] {
    ST_STANDBY = 4'h1,
    ST_READING = 4'h2,
    ST_SUSPEND = 4'h4,
    ST_POWERDOWN = 4'h8
  } devState_t;

endpackage

// ==== hdl/sync_burst_rom_read_port.sv ====
// Command decode, mode settings, burst sequencing and output stage of the ROM read port

// Behaviour
// - Eight-beat bursts step low three column bits, sequential add or interleave XOR.
// - x32 reads take 13 row bits and 7 column bits, upper lines ignored.
// - x16 reads take 13 row bits and 8 column bits, lines 8-12 ignored.
// - Column bit 1 tops a four-beat burst, bit 2 an eight-beat; higher bits fixed.
// - x32 puts the lower half-word on DQ 0-15, upper on DQ 16-31.
// - One x32 word sits at half the x16 address; bit 0 picks the half.
// - Clock enable sampled on one edge admits or suppresses the next edge.
// - With the internal clock suppressed, commands are ignored and all state holds except the operating state and the illegal-command flag.
// - Clock enable low in standby is power down, keeping mode and row.
// - Clock enable low during a read suspends it without aborting it.
// - Power-on defaults are latency 5, sequential order, burst length 4.
// - After power on the port is in standby and accepts commands at once.
// - Width select is sampled with every read: high x32, low x16.
// - Mode settings are latency, order and length; no row-to-column setting.
// - Mode register set is accepted when no read is in flight and no earlier mode set is blanking commands, for later reads.
// - Mode code: bits 5-3 latency, bit 2 order, bits 1-0 length; 7, 8 low.
// - First datum is sampled at the edge the programmed latency after the read.
// - Mask sampled high places the data outputs in high impedance two edges later.
module sync_burst_rom_read_port (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic reset,
  // Command and address pins
  input wire logic clockEn,
  input wire logic chipSelN,
  input wire logic rowStrobeN,
  input wire logic colStrobeN,
  input wire logic modeCmdStrobeN,
  input wire logic wordSel,
  input wire logic outMask,
  input wire logic [sync_rom_pkg::ADDR_W-1:0] addr,
  // Data pins, low half and high half enables active low
  output logic [sync_rom_pkg::DATA_W-1:0] dataOut,
  output logic [1:0] dataOeN,
  // Array read port, data returned within the cycle of the address, taken on the next edge
  output logic [sync_rom_pkg::ARR_AW-1:0] arrayAddr,
  input wire logic [sync_rom_pkg::DATA_W-1:0] arrayData,
  // Status
  output logic inPowerDown,
  output logic inSuspend,
  output logic illegalCmd
);

  // ****************************************
  // Declarations
  // ****************************************
  logic ckeQ_ff, illegalCmd_ff;
  sync_rom_pkg::devState_t state_ff, nxt_state;
  logic [2:0] latency_ff, pendWait_ff, issueBeat_ff;
  logic interleave_ff, len8_ff;
  logic [1:0] mrsBlank_ff, dataOeN_ff;
  logic [sync_rom_pkg::ROW_W-1:0] rowAddr_ff;
  logic pendValid_ff, pendWide_ff, pendLen8_ff, pendInter_ff;
  logic [sync_rom_pkg::COL_W-1:0] pendCol_ff, issueCol_ff;
  logic issueActive_ff, issueWide_ff, issueLen8_ff, issueInter_ff;
  logic issuedQ_ff, halfQ_ff, wideQ_ff, maskQ_ff;
  logic [sync_rom_pkg::DATA_W-1:0] dataOut_ff;
  logic [sync_rom_pkg::ARR_AW-1:0] arrayAddr_ff;
  logic en, cmdOk, isAct, isRead, isMrs, takePend, doIssue, busy;
  logic [sync_rom_pkg::COL_W-1:0] srcCol, beatCol;
  logic [2:0] srcBeat, beatMask, beatLow;
  logic srcWide, srcLen8, srcInter;

  // ****************************************
  // Internal clock admission and command decode
  // ****************************************
  // Enable seen on the previous edge admits this one
  assign en = ckeQ_ff;
  // Commands need enable held, chip select and no mode-set blanking
  assign cmdOk = en && !chipSelN && clockEn && (mrsBlank_ff == 2'h0);
  assign isAct = cmdOk && !rowStrobeN && colStrobeN && modeCmdStrobeN;
  assign isRead = cmdOk && rowStrobeN && !colStrobeN && modeCmdStrobeN;
  assign isMrs = cmdOk && !rowStrobeN && !colStrobeN && !modeCmdStrobeN;

  // Gate sample runs on every edge, outside the suppressed domain
  always_ff @(posedge clk) begin
    if (reset) begin
      ckeQ_ff <= 1'b1;
    end else begin
      ckeQ_ff <= clockEn;
    end
  end

  // Flags a command issued while enable is falling
  always_ff @(posedge clk) begin
    if (reset) begin
      illegalCmd_ff <= 1'b0;
    end else begin
      illegalCmd_ff <= en && !clockEn && !chipSelN
        && !(rowStrobeN && colStrobeN && modeCmdStrobeN);
    end
  end

  // ****************************************
  // Operating state
  // ****************************************
  assign busy = pendValid_ff || issueActive_ff || issuedQ_ff;

  // Next state follows the enable level and whether a read is in flight
  always_comb begin
    case (state_ff)
      sync_rom_pkg::ST_STANDBY, sync_rom_pkg::ST_READING,
      sync_rom_pkg::ST_SUSPEND, sync_rom_pkg::ST_POWERDOWN: begin
        if (!clockEn) begin
          nxt_state = busy ? sync_rom_pkg::ST_SUSPEND : sync_rom_pkg::ST_POWERDOWN;
        end else begin
          nxt_state = busy ? sync_rom_pkg::ST_READING : sync_rom_pkg::ST_STANDBY;
        end
      end
      default: begin
        nxt_state = sync_rom_pkg::ST_STANDBY;
      end
    endcase
  end

  // State register, ready for commands straight after power on
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= sync_rom_pkg::ST_STANDBY;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************
  // Mode settings and row latch
  // ****************************************
  // Mode register set with reserved codes leaving fields unchanged
  always_ff @(posedge clk) begin
    if (reset) begin
      latency_ff <= sync_rom_pkg::RESET_LAT;
      interleave_ff <= sync_rom_pkg::RESET_INTERLEAVE;
      len8_ff <= sync_rom_pkg::RESET_LEN8;
    end else if (isMrs && !busy && !addr[sync_rom_pkg::MR_RSV_LO_BIT]
        && !addr[sync_rom_pkg::MR_RSV_HI_BIT]) begin
      if (addr[sync_rom_pkg::MR_LAT_LSB +: 3] == sync_rom_pkg::LAT_CODE_4) begin
        latency_ff <= sync_rom_pkg::LAT_4;
      end else if (addr[sync_rom_pkg::MR_LAT_LSB +: 3] == sync_rom_pkg::LAT_CODE_5) begin
        latency_ff <= sync_rom_pkg::LAT_5;
      end
      interleave_ff <= addr[sync_rom_pkg::MR_TYPE_BIT];
      if (addr[sync_rom_pkg::MR_LEN_LSB +: 2] == sync_rom_pkg::LEN_CODE_4) begin
        len8_ff <= 1'b0;
      end else if (addr[sync_rom_pkg::MR_LEN_LSB +: 2] == sync_rom_pkg::LEN_CODE_8) begin
        len8_ff <= 1'b1;
      end
    end
  end

  // Blanks command sampling for three admitted edges after a mode set
  always_ff @(posedge clk) begin
    if (reset) begin
      mrsBlank_ff <= 2'h0;
    end else if (isMrs) begin
      mrsBlank_ff <= sync_rom_pkg::MRS_BLANK;
    end else if (en && mrsBlank_ff != 2'h0) begin
      mrsBlank_ff <= mrsBlank_ff - 2'h1;
    end
  end

  // Row address kept through power down until the next activate
  always_ff @(posedge clk) begin
    if (reset) begin
      rowAddr_ff <= '0;
    end else if (isAct) begin
      rowAddr_ff <= addr[sync_rom_pkg::ROW_W-1:0];
    end
  end

  // ****************************************
  // Pending read waiting out the latency
  // ****************************************
  assign takePend = en && pendValid_ff && (pendWait_ff == 3'h0);

  // Read captures column, width and mode; a newer read replaces it
  always_ff @(posedge clk) begin
    if (reset) begin
      pendValid_ff <= 1'b0;
      pendWait_ff <= 3'h0;
      pendCol_ff <= '0;
      pendWide_ff <= 1'b0;
      pendLen8_ff <= 1'b0;
      pendInter_ff <= 1'b0;
    end else if (isRead) begin
      pendValid_ff <= 1'b1;
      pendWait_ff <= latency_ff - sync_rom_pkg::ISSUE_LEAD;
      pendCol_ff <= wordSel ? {1'b0, addr[6:0]} : addr[7:0];
      pendWide_ff <= wordSel;
      pendLen8_ff <= len8_ff;
      pendInter_ff <= interleave_ff;
    end else if (takePend) begin
      pendValid_ff <= 1'b0;
    end else if (en && pendValid_ff) begin
      pendWait_ff <= pendWait_ff - 3'h1;
    end
  end

  // ****************************************
  // Burst address sequencing
  // ****************************************
  assign doIssue = takePend || (en && issueActive_ff);
  assign srcCol = takePend ? pendCol_ff : issueCol_ff;
  assign srcBeat = takePend ? 3'h0 : issueBeat_ff;
  assign srcWide = takePend ? pendWide_ff : issueWide_ff;
  assign srcLen8 = takePend ? pendLen8_ff : issueLen8_ff;
  assign srcInter = takePend ? pendInter_ff : issueInter_ff;

  // Only the low two or three column bits move within a burst
  assign beatMask = srcLen8 ? sync_rom_pkg::MASK_LEN8 : sync_rom_pkg::MASK_LEN4;
  assign beatLow = srcInter ? (srcCol[2:0] ^ srcBeat) : (srcCol[2:0] + srcBeat);
  assign beatCol = {srcCol[7:3], (srcCol[2:0] & ~beatMask) | (beatLow & beatMask)};

  // Burst tracker; a pending read taking over ends the older burst
  always_ff @(posedge clk) begin
    if (reset) begin
      issueActive_ff <= 1'b0;
      issueCol_ff <= '0;
      issueBeat_ff <= 3'h0;
      issueWide_ff <= 1'b0;
      issueLen8_ff <= 1'b0;
      issueInter_ff <= 1'b0;
    end else if (doIssue) begin
      issueActive_ff <= (srcBeat != beatMask);
      issueCol_ff <= srcCol;
      issueBeat_ff <= srcBeat + 3'h1;
      issueWide_ff <= srcWide;
      issueLen8_ff <= srcLen8;
      issueInter_ff <= srcInter;
    end
  end

  // Array address: x32 word at half the x16 address
  always_ff @(posedge clk) begin
    if (reset) begin
      arrayAddr_ff <= '0;
      halfQ_ff <= 1'b0;
      wideQ_ff <= 1'b0;
    end else if (doIssue) begin
      arrayAddr_ff <= srcWide ? {rowAddr_ff, beatCol[6:0]}
                              : {rowAddr_ff, beatCol[7:1]};
      halfQ_ff <= beatCol[0];
      wideQ_ff <= srcWide;
    end
  end

  // ****************************************
  // Output stage
  // ****************************************
  // Marks an array fetch to be driven on the next admitted edge
  always_ff @(posedge clk) begin
    if (reset) begin
      issuedQ_ff <= 1'b0;
      maskQ_ff <= 1'b1;
    end else if (en) begin
      issuedQ_ff <= doIssue;
      maskQ_ff <= outMask;
    end
  end

  // Drives fetched data; floats after the last beat or when masked
  always_ff @(posedge clk) begin
    if (reset) begin
      dataOut_ff <= '0;
      dataOeN_ff <= 2'h3;
    end else if (en) begin
      if (issuedQ_ff) begin
        dataOut_ff[sync_rom_pkg::HALF_W-1:0] <= (!wideQ_ff && halfQ_ff)
          ? arrayData[sync_rom_pkg::DATA_W-1:sync_rom_pkg::HALF_W]
          : arrayData[sync_rom_pkg::HALF_W-1:0];
        dataOut_ff[sync_rom_pkg::DATA_W-1:sync_rom_pkg::HALF_W] <=
          arrayData[sync_rom_pkg::DATA_W-1:sync_rom_pkg::HALF_W];
      end
      dataOeN_ff[0] <= !(issuedQ_ff && !maskQ_ff);
      dataOeN_ff[1] <= !(issuedQ_ff && wideQ_ff && !maskQ_ff);
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign dataOut = dataOut_ff;
  assign dataOeN = dataOeN_ff;
  assign arrayAddr = arrayAddr_ff;
  assign inPowerDown = state_ff[3];
  assign inSuspend = state_ff[2];
  assign illegalCmd = illegalCmd_ff;
endmodule

// ==== verif/sync_rom_monitor.sv ====
// Port-level checker for the ROM read port
module sync_rom_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Command pins
  input wire logic clockEn,
  input wire logic chipSelN,
  input wire logic rowStrobeN,
  input wire logic colStrobeN,
  input wire logic modeCmdStrobeN,
  input wire logic wordSel,
  input wire logic outMask,
  input wire logic [sync_rom_pkg::ADDR_W-1:0] addr,
  // Data and array
  input wire logic [sync_rom_pkg::DATA_W-1:0] dataOut,
  input wire logic [sync_rom_pkg::DATA_W-1:0] arrayData,
  input wire logic [1:0] dataOeN,
  input wire logic [sync_rom_pkg::ARR_AW-1:0] arrayAddr,
  // Status
  input wire logic inPowerDown,
  input wire logic inSuspend,
  input wire logic illegalCmd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic admit_ff;
  logic rdCmd;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Tracks whether the current edge is admitted into the port
  always_ff @(posedge clk) begin
    if (reset) begin
      admit_ff <= 1'b1;
    end else begin
      admit_ff <= clockEn;
    end
  end
  // Read command that the port takes
  assign rdCmd = admit_ff && clockEn && !chipSelN && rowStrobeN && !colStrobeN && modeCmdStrobeN;
  sequence oe_start;
    dataOeN != 2'b11 && $past(dataOeN) == 2'b11 && !$past(outMask, 2) && !$past(outMask, 3);
  endsequence
  sequence clock_run;
    $past(clockEn, 2) && $past(clockEn, 3) && $past(clockEn, 4) && $past(clockEn, 5);
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  reset_defaults_a: assert property (disable iff (1'b0) reset |=> dataOeN == 2'b11
    && !inPowerDown && !inSuspend && !illegalCmd) else $error("outputs not idle after reset");
  drive_latency_a: assert property (oe_start ##0 clock_run |->
    $past(rdCmd, 4) || $past(rdCmd, 5)) else $error("data driven off the read latency");
  mask_float_a: assert property (admit_ff && clockEn && outMask |-> ##2 dataOeN == 2'b11)
    else $error("masked data still driven");
  frozen_hold_a: assert property (!clockEn |-> ##2 $stable(dataOut) && $stable(dataOeN)
    && $stable(arrayAddr)) else $error("outputs moved on a suppressed edge");
  illegal_pulse_a: assert property (admit_ff && !clockEn && !chipSelN && rowStrobeN
    && !colStrobeN && modeCmdStrobeN |=> illegalCmd) else $error("illegal command not flagged");
  powerdown_entry_a: assert property ($rose(inPowerDown) |-> !$past(clockEn))
    else $error("power down without clock enable low");
  suspend_entry_a: assert property ($rose(inSuspend) |-> !$past(clockEn))
    else $error("suspend without clock enable low");
  state_exclusive_a: assert property (!(inSuspend && inPowerDown))
    else $error("suspend and power down together");
endmodule

bind sync_burst_rom_read_port sync_rom_monitor i_mon (.clk(clk), .reset(reset),
  .clockEn(clockEn), .chipSelN(chipSelN), .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN),
  .modeCmdStrobeN(modeCmdStrobeN), .wordSel(wordSel), .outMask(outMask), .addr(addr),
  .dataOut(dataOut), .dataOeN(dataOeN), .arrayAddr(arrayAddr), .arrayData(arrayData),
  .inPowerDown(inPowerDown), .inSuspend(inSuspend), .illegalCmd(illegalCmd));

// ==== verif/rom_array_model.sv ====
// Array model that answers the read port within the cycle of the address
module rom_array_model (
  // Array port
  input wire logic [sync_rom_pkg::ARR_AW-1:0] arrayAddr,
  output logic [sync_rom_pkg::DATA_W-1:0] arrayData
);
  timeunit 1ns;
  timeprecision 1ps;
  // Each half depends on the whole column so a wrong row, column or beat shows
  assign arrayData = {arrayAddr[7:0], arrayAddr[19:12], arrayAddr[15:0]};
endmodule

// ==== verif/sync_burst_rom_read_port_tb_top.sv ====
// Self-checking testbench of the ROM read port
module sync_burst_rom_read_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, clockEn, chipSelN, rowStrobeN, colStrobeN, modeCmdStrobeN, wordSel, outMask;
  logic [12:0] addr, row;
  logic [31:0] dataOut, arrayData;
  logic [19:0] arrayAddr;
  logic [1:0] dataOeN;
  logic inPowerDown, inSuspend, illegalCmd;
  int err_total = 0;
  int cmp_count = 0;

  sync_burst_rom_read_port i_dut (.clk(clk), .reset(reset), .clockEn(clockEn),
    .chipSelN(chipSelN), .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN),
    .modeCmdStrobeN(modeCmdStrobeN), .wordSel(wordSel), .outMask(outMask), .addr(addr),
    .dataOut(dataOut), .dataOeN(dataOeN), .arrayAddr(arrayAddr), .arrayData(arrayData),
    .inPowerDown(inPowerDown), .inSuspend(inSuspend), .illegalCmd(illegalCmd));
  rom_array_model i_array (.arrayAddr(arrayAddr), .arrayData(arrayData));

  // 100 MHz clock
  always #5 clk = ~clk;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One command cycle, then deselect
  task automatic cmd(input logic ras, cas, mr, input logic [12:0] a, input logic ws);
    @(posedge clk);
    chipSelN <= 1'b0;
    rowStrobeN <= ras;
    colStrobeN <= cas;
    modeCmdStrobeN <= mr;
    addr <= a;
    wordSel <= ws;
    @(posedge clk);
    chipSelN <= 1'b1;
    rowStrobeN <= 1'b1;
    colStrobeN <= 1'b1;
    modeCmdStrobeN <= 1'b1;
  endtask

  task automatic act(input logic [12:0] r);
    cmd(1'b0, 1'b1, 1'b1, r, 1'b0);
    row = r;
  endtask

  task automatic mset(input logic [12:0] code);
    cmd(1'b0, 1'b0, 1'b0, code, 1'b0);
    repeat (3) @(posedge clk);
  endtask

  // Read and judge every beat; sus names the beat where clock enable dips
  task automatic rd(input logic [12:0] a, input logic ws, input int lat, len, ilv, sus);
    logic [7:0] c, m, cb;
    logic [31:0] w;
    logic [19:0] wa;
    int k;
    bit hold;
    m = (len == 8) ? 8'h07 : 8'h03;
    c = ws ? {1'b0, a[6:0]} : a[7:0];
    cmd(1'b1, 1'b0, 1'b1, a, ws);
    repeat (lat - 1) @(posedge clk);
    k = 0;
    hold = 0;
    while (k < len) begin
      cb = (c & ~m) | ((ilv != 0 ? c ^ k[7:0] : c + k[7:0]) & m);
      // Word at half the x16 address; x16 shows the half named by column bit 0
      wa = ws ? {row, cb[6:0]} : {row, cb[7:1]};
      w = {wa[7:0], wa[19:12], wa[15:0]};
      w = ws ? w : (cb[0] ? {16'h0000, w[31:16]} : {16'h0000, w[15:0]});
      #1;
      chk("beat data", w, ws ? dataOut : {16'h0000, dataOut[15:0]});
      chk("beat enables", ws ? 32'h0000_0000 : 32'h0000_0002, 32'(dataOeN));
      if (hold) chk("suspend flag", 32'h0000_0001, 32'(inSuspend));
      @(posedge clk);
      if (hold) hold = 0;
      else k++;
      if (!clockEn) begin
        clockEn <= 1'b1;
        hold = 1;
      end
      else if (k == sus) clockEn <= 1'b0;
    end
    #1;
    chk("enables after burst", 32'h0000_0003, 32'(dataOeN));
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_default();
    act(13'h1ABC);
    outMask <= 1'b0;
    rd(13'h1F85, 1'b1, 5, 4, 0, -1);
  endtask

  task automatic t_modes();
    logic [12:0] code;
    for (int i = 0; i < 8; i++) begin
      code = {7'h00, i[0] ? sync_rom_pkg::LAT_CODE_4 : sync_rom_pkg::LAT_CODE_5, i[1],
              i[2] ? sync_rom_pkg::LEN_CODE_8 : sync_rom_pkg::LEN_CODE_4};
      mset(code);
      rd({5'h1F, 8'(8'h0B + i * 29)}, i[0] ^ i[1], i[0] ? 4 : 5, i[2] ? 8 : 4, i[1], -1);
    end
  endtask

  task automatic t_illegal();
    @(posedge clk);
    clockEn <= 1'b0;
    chipSelN <= 1'b0;
    colStrobeN <= 1'b0;
    @(posedge clk);
    clockEn <= 1'b1;
    chipSelN <= 1'b1;
    colStrobeN <= 1'b1;
    #1;
    chk("illegal flag", 32'h0000_0001, 32'(illegalCmd));
    repeat (8) begin
      @(posedge clk);
      #1;
      chk("refused read", 32'h0000_0003, 32'(dataOeN));
    end
  endtask

  task automatic t_suspend();
    act(13'h0155);
    mset({7'h00, sync_rom_pkg::LAT_CODE_4, 1'b0, sync_rom_pkg::LEN_CODE_8});
    rd(13'h0A3D, 1'b1, 4, 8, 0, 3);
  endtask

  task automatic t_power();
    @(posedge clk);
    clockEn <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("power down flag", 32'h0000_0001, 32'(inPowerDown));
    @(posedge clk);
    clockEn <= 1'b1;
    repeat (2) @(posedge clk);
    rd(13'h00C6, 1'b0, 4, 8, 0, -1);
  endtask

  // Masks the second beat of an eight-beat x32 burst
  task automatic t_mask();
    cmd(1'b1, 1'b0, 1'b1, 13'h0010, 1'b1);
    repeat (2) @(posedge clk);
    outMask <= 1'b1;
    @(posedge clk);
    outMask <= 1'b0;
    #1;
    chk("enables before mask", 32'h0000_0000, 32'(dataOeN));
    @(posedge clk);
    #1;
    chk("masked enables", 32'h0000_0003, 32'(dataOeN));
    @(posedge clk);
    #1;
    chk("unmasked enables", 32'h0000_0000, 32'(dataOeN));
    repeat (8) @(posedge clk);
    #1;
    chk("enables after masked burst", 32'h0000_0003, 32'(dataOeN));
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    clockEn = 1'b1;
    chipSelN = 1'b1;
    rowStrobeN = 1'b1;
    colStrobeN = 1'b1;
    modeCmdStrobeN = 1'b1;
    wordSel = 1'b0;
    outMask = 1'b1;
    addr = 13'h0000;
    row = 13'h0000;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk("reset enables", 32'h0000_0003, 32'(dataOeN));
    t_default();
    t_modes();
    t_illegal();
    t_suspend();
    t_power();
    t_mask();
    end_sim();
  end

  initial begin
    #100000;
    err_total++;
    end_sim();
  end
endmodule
